// file: osp_fifo.sv
`default_nettype none
module osp_fifo #(
	parameter int WIDTH = 14,
	parameter int DEPTH = 8
) (
	// Clock and reset
	input wire logic clk_sys_i,
	input wire logic rst_n_i,
	// Stream
	osp_fifo_if.fifo f
);
	localparam int AW = $clog2(DEPTH);
	typedef struct packed {
		logic [AW:0] wptr;
		logic [AW:0] rptr;
	} osp_fifo_s;
	logic [WIDTH-1:0] mem [DEPTH];
	osp_fifo_s q;
	osp_fifo_s next_q;
	logic full;
	logic empty;
	always_comb begin
		empty = (q.wptr == q.rptr);
		full = (q.wptr[AW] != q.rptr[AW]) && (q.wptr[AW-1:0] == q.rptr[AW-1:0]);
		next_q = q;
		if (f.wr_valid && !full) begin
			next_q.wptr = q.wptr + 1'b1;
		end
		if (f.rd_ready && !empty) begin
			next_q.rptr = q.rptr + 1'b1;
		end
	end
	always_ff @(posedge clk_sys_i) begin
		if (f.wr_valid && !full) begin
			mem[q.wptr[AW-1:0]] <= f.wr_data;
		end
	end
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			q <= '0;
		end else begin
			q <= next_q;
		end
	end
	assign f.wr_ready = !full;
	assign f.rd_valid = !empty;
	assign f.rd_data = mem[q.rptr[AW-1:0]];
endmodule
`default_nettype wire

// file: osp_fifo_if.sv
`default_nettype none
interface osp_fifo_if;
	logic [osp_pkg::FIFO_WIDTH-1:0] wr_data;
	logic wr_valid;
	logic wr_ready;
	logic [osp_pkg::FIFO_WIDTH-1:0] rd_data;
	logic rd_valid;
	logic rd_ready;
	modport producer(output wr_data, output wr_valid, input wr_ready, input rd_data, input rd_valid, output rd_ready);
	modport fifo(input wr_data, input wr_valid, output wr_ready, output rd_data, output rd_valid, input rd_ready);
endinterface
`default_nettype wire

// file: osp_pkg.sv
`default_nettype none
package osp_pkg;
	localparam int CMD_BITS = 6;
	localparam int DATA_BITS = 14;
	localparam int FRAME_CYCLES = 16;
	localparam int ADDR_BITS = 14;
	localparam logic [5:0] CMD_LOAD_CFG = 6'h00;
	localparam logic [5:0] CMD_LOAD_DATA = 6'h02;
	localparam logic [5:0] CMD_READ_DATA = 6'h04;
	localparam logic [5:0] CMD_INC_ADDR = 6'h06;
	localparam logic [5:0] CMD_BEGIN_PROG = 6'h08;
	localparam logic [5:0] CMD_END_PROG = 6'h0E;
	localparam logic [13:0] ADDR_USER_BASE = 14'h0000;
	localparam logic [13:0] ADDR_CFG_BASE = 14'h2000;
	localparam int CFG_BIT = 13;
	localparam logic [12:0] USER_MASK = 13'h0FFF;
	localparam logic [12:0] CFG_MASK = 13'h00FF;
	localparam logic [4:0] BIT_CNT_ZERO = 5'h00;
	localparam logic [4:0] DATA_FIRST = 5'h01;
	localparam logic [4:0] DATA_LAST = 5'h0E;
	localparam logic [4:0] CMD_LAST = 5'h05;
	localparam logic [4:0] FRAME_LAST = 5'h0F;
	localparam int FIFO_WIDTH = 14;
	localparam int FIFO_DEPTH = 8;
	typedef enum logic [1:0] {OSP_CMD, OSP_WDATA, OSP_RDATA} osp_phase_e;
endpackage
`default_nettype wire

// file: osp_port.sv
// Notes on behaviour
// R1: Programmer holds clock, data low at entry.
// R2: Programmer raises master clear before supply.
// R3: Entry holds other logic reset, pins input.
// R4: Entry selects user memory, serial access.
// R5: Address counter starts at zero.
// R6: Six-bit commands, LSb first, falling-edge capture.
// R7: Data frame: start, fourteen bits, stop.
// R8: One microsecond before data phase.
// R9: One microsecond between commands.
// R10: Decode the six documented command codes.
// R11: Load configuration sets address to 0x2000.
// R12: Load data captures fourteen-bit word.
// R13: Read drives pin from second rising edge.
// R14: Read returns addressed word of selected space.
// R15: Increment command advances address by one.
// R16: Wrap within user or configuration space.
// R17: Configuration selection sticks until re-entry.
// R18: Program accesses alias onto implemented memory.
// R19: Configuration segment aliases beyond its end.
// R20: Programmer uses low ID bits only.
// R21: Load precedes every begin programming.
// R22: Burn from begin until end programming.
// R23: End programming stops the burn.
// R24: Device operating clock stays disabled.
`default_nettype none
module osp_port
	import osp_pkg::*;
(
	// Clock and reset
	input wire logic clk_sys_i,
	input wire logic rst_n_i,
	// Programming pins
	input wire logic master_clear_pin_i,
	input wire logic serial_clock_pin_i,
	input wire logic serial_data_pin_i,
	output logic serial_data_pin_o,
	output logic serial_data_pin_oe_n_o,
	// Mode and memory array side
	output logic prog_mode_o,
	output logic hold_reset_o,
	output logic [osp_pkg::ADDR_BITS-1:0] mem_addr_o,
	output logic [osp_pkg::DATA_BITS-1:0] burn_data_o,
	output logic burn_o,
	input wire logic [osp_pkg::DATA_BITS-1:0] mem_rdata_i,
	input wire logic wide_variant_i
);
	import osp_pkg::*;

	////////////////////////////////////////////////////////////////////////////////
	typedef struct packed {
		logic [1:0] master_clear_pin_sync;
		logic [1:0] clk_sync;
		logic [1:0] dat_sync;
		logic clk_prev;
		logic active;
		logic hold;
		osp_phase_e phase;
		logic [4:0] cnt;
		logic [5:0] cmd;
		logic [13:0] shreg;
		logic [13:0] addr;
		logic [13:0] latch;
		logic load_seen;
		logic burn;
		logic dout;
		logic oe_n;
		logic [13:0] mem_addr;
	} osp_state_s;

	osp_state_s q;
	osp_state_s next_q;
	osp_fifo_if fif();

	osp_fifo #(.WIDTH(FIFO_WIDTH), .DEPTH(FIFO_DEPTH)) u_fifo (
		.clk_sys_i(clk_sys_i),
		.rst_n_i(rst_n_i),
		.f(fif.fifo)
	);

	// Next address with wrap inside the selected half; the top bit never falls back.
	function automatic logic [13:0] osp_inc(input logic [13:0] a);
		logic [12:0] low;
		low = a[12:0] + 13'h0001;
		return {a[CFG_BIT], low}; // R15 R16 R17
	endfunction

	// Physical location: program space aliases on implemented depth, config on its segment.
	function automatic logic [13:0] osp_phys(input logic [13:0] a, input logic wide);
		logic [12:0] m;
		m = a[CFG_BIT] ? (wide ? CFG_MASK : (CFG_MASK >> 1)) : (wide ? USER_MASK : (USER_MASK >> 1));
		return {a[CFG_BIT], a[12:0] & m}; // R18 R19
	endfunction

	logic rise;
	logic fall;
	logic cmd_done;

	////////////////////////////////////////////////////////////////////////////////
	always_comb begin
		next_q = q;
		next_q.master_clear_pin_sync = {q.master_clear_pin_sync[0], master_clear_pin_i};
		next_q.clk_sync = {q.clk_sync[0], serial_clock_pin_i};
		next_q.dat_sync = {q.dat_sync[0], serial_data_pin_i};
		next_q.clk_prev = q.clk_sync[1];
		// The hold outlasts the mode by a cycle on exit, so the rest of the chip never runs while the port is live.
		next_q.hold = q.master_clear_pin_sync[1] || q.active; // R3
		rise = q.clk_sync[1] && !q.clk_prev;
		fall = !q.clk_sync[1] && q.clk_prev;
		cmd_done = 1'b0;
		fif.wr_valid = 1'b0;
		fif.wr_data = q.shreg;
		fif.rd_ready = 1'b0;

		if (!q.master_clear_pin_sync[1]) begin
			// Leaving the mode drops the phase, count, burn, load flag, pin drive and config selection; the burn word latch and FIFO keep their contents.
			next_q.active = 1'b0;
			next_q.phase = OSP_CMD;
			next_q.cnt = BIT_CNT_ZERO;
			next_q.addr = ADDR_USER_BASE; // R5 R17
			next_q.burn = 1'b0;
			next_q.oe_n = 1'b1;
			next_q.load_seen = 1'b0;
		end else begin
			// The first edge seen in mode is the programmer's first command clock.
			next_q.active = 1'b1; // R4
			case (q.phase)
				OSP_CMD: begin
					if (fall) begin
						next_q.cmd = {q.dat_sync[1], q.cmd[5:1]}; // R6
						if (q.cnt == CMD_LAST) begin
							next_q.cnt = BIT_CNT_ZERO;
							cmd_done = 1'b1;
						end else begin
							next_q.cnt = q.cnt + 5'h01;
						end
					end
				end
				OSP_WDATA: begin
					if (fall) begin
						if (q.cnt >= DATA_FIRST && q.cnt <= DATA_LAST) begin
							next_q.shreg = {q.dat_sync[1], q.shreg[13:1]}; // R7 R12
						end
						if (q.cnt == FRAME_LAST) begin
							next_q.phase = OSP_CMD;
							next_q.cnt = BIT_CNT_ZERO;
							fif.wr_valid = 1'b1;
						end else begin
							next_q.cnt = q.cnt + 5'h01;
						end
					end
				end
				OSP_RDATA: begin
					if (rise) begin
						if (q.cnt >= DATA_FIRST && q.cnt <= DATA_LAST) begin
							next_q.oe_n = 1'b0; // R13
							next_q.dout = q.shreg[0];
							next_q.shreg = {1'b0, q.shreg[13:1]};
						end else if (q.cnt == FRAME_LAST) begin
							next_q.oe_n = 1'b1; // R13
							next_q.dout = 1'b0;
						end
					end
					if (fall) begin
						if (q.cnt == FRAME_LAST) begin
							next_q.phase = OSP_CMD;
							next_q.cnt = BIT_CNT_ZERO;
						end else begin
							next_q.cnt = q.cnt + 5'h01;
						end
					end
				end
				default: begin
					next_q.phase = OSP_CMD;
				end
			endcase

			if (cmd_done) begin
				case (next_q.cmd) // R10
					CMD_LOAD_CFG: begin
						next_q.addr = ADDR_CFG_BASE; // R11 R17
						next_q.phase = OSP_WDATA;
						next_q.load_seen = 1'b1;
					end
					CMD_LOAD_DATA: begin
						next_q.phase = OSP_WDATA;
						next_q.load_seen = 1'b1;
					end
					CMD_READ_DATA: begin
						next_q.phase = OSP_RDATA;
						next_q.shreg = mem_rdata_i; // R14
					end
					CMD_INC_ADDR: begin
						next_q.addr = osp_inc(q.addr); // R15
					end
					CMD_BEGIN_PROG: begin
						// Without a preceding load there is no word to burn, so the command is ignored.
						if (q.load_seen && fif.rd_valid) begin
							next_q.burn = 1'b1; // R22
							next_q.latch = fif.rd_data;
							fif.rd_ready = 1'b1;
							next_q.load_seen = 1'b0; // R21
						end
					end
					CMD_END_PROG: begin
						next_q.burn = 1'b0; // R23
					end
					default: begin
						next_q.cmd = q.cmd;
					end
				endcase
			end
			// Discard a stale loaded word when a new load arrives without a burn.
			if (cmd_done && (next_q.cmd == CMD_LOAD_CFG || next_q.cmd == CMD_LOAD_DATA) && fif.rd_valid) begin
				fif.rd_ready = 1'b1;
			end
		end
		next_q.mem_addr = osp_phys(next_q.addr, wide_variant_i);
	end

	////////////////////////////////////////////////////////////////////////////////
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			q <= '0;
			q.oe_n <= 1'b1;
			q.phase <= OSP_CMD;
		end else begin
			q <= next_q;
		end
	end

	assign serial_data_pin_o = q.dout;
	assign serial_data_pin_oe_n_o = q.oe_n;
	assign prog_mode_o = q.active;
	assign hold_reset_o = q.hold; // R3
	assign mem_addr_o = q.mem_addr;
	assign burn_data_o = q.latch;
	assign burn_o = q.burn; // R22
endmodule
`default_nettype wire

// file: osp_port_props.sv
`default_nettype none
module osp_port_props (
	// Clock and reset
	input wire logic clk_sys_i,
	input wire logic rst_n_i,
	// Programming pins
	input wire logic master_clear_pin_i,
	input wire logic serial_clock_pin_i,
	input wire logic serial_data_pin_i,
	input wire logic serial_data_pin_o,
	input wire logic serial_data_pin_oe_n_o,
	// Mode and memory array side
	input wire logic prog_mode_o,
	input wire logic hold_reset_o,
	input wire logic [osp_pkg::ADDR_BITS-1:0] mem_addr_o,
	input wire logic [osp_pkg::DATA_BITS-1:0] burn_data_o,
	input wire logic burn_o,
	input wire logic [osp_pkg::DATA_BITS-1:0] mem_rdata_i,
	input wire logic wide_variant_i
);
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (!rst_n_i);
	////////////////////////////////////////////////////////////////
	sequence mode_up_s; $rose(prog_mode_o); endsequence
	// A link half period is at least four system clocks, so a read bit keeps the pin eight cycles at least.
	sequence drive_win_s; !serial_data_pin_oe_n_o [*8]; endsequence
	mode_hold_a: assert property (prog_mode_o |-> hold_reset_o) else $error("hold released in mode");
	pin_input_a: assert property (!prog_mode_o |-> serial_data_pin_oe_n_o) else $error("pin driven out of mode");
	entry_addr_a: assert property (mode_up_s |-> mem_addr_o == '0) else $error("entry address not zero");
	mode_entry_a: assert property ($rose(master_clear_pin_i) |-> ##[1:5] prog_mode_o) else $error("no entry");
	mode_exit_a: assert property ($fell(master_clear_pin_i) |-> ##[1:5] !prog_mode_o) else $error("no exit");
	cfg_stick_a:
		assert property (prog_mode_o && mem_addr_o[13] |=> mem_addr_o[13] || !prog_mode_o) else $error("left cfg");
	cfg_alias_a:
		assert property (mem_addr_o[13] |-> mem_addr_o[12:8] == '0 && (wide_variant_i || !mem_addr_o[7]))
		else $error("cfg address beyond segment");
	user_alias_a:
		assert property (!mem_addr_o[13] |-> !mem_addr_o[12] && (wide_variant_i || !mem_addr_o[11]))
		else $error("user address beyond array");
	burn_hold_a: assert property (burn_o && $past(burn_o) |-> $stable(burn_data_o)) else $error("burn word moved");
	read_drive_a: assert property ($fell(serial_data_pin_oe_n_o) |-> drive_win_s) else $error("short drive");
endmodule
bind osp_port osp_port_props u_osp_port_props (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
	.master_clear_pin_i(master_clear_pin_i), .serial_clock_pin_i(serial_clock_pin_i),
	.serial_data_pin_i(serial_data_pin_i), .serial_data_pin_o(serial_data_pin_o),
	.serial_data_pin_oe_n_o(serial_data_pin_oe_n_o), .prog_mode_o(prog_mode_o), .hold_reset_o(hold_reset_o),
	.mem_addr_o(mem_addr_o), .burn_data_o(burn_data_o), .burn_o(burn_o), .mem_rdata_i(mem_rdata_i),
	.wide_variant_i(wide_variant_i));
`default_nettype wire

// file: osp_port_test.sv
`default_nettype none
module osp_port_test;
	timeunit 1ns;
	timeprecision 1ns;
	import osp_pkg::*;
	logic clk_sys_i;
	logic rst_n_i;
	logic master_clear_pin_i;
	logic wide_variant_i;
	logic [13:0] mem_rdata_i;
	logic sclk;
	logic sdat;
	logic data_o;
	logic oe_n;
	logic mode;
	logic hold;
	logic [13:0] addr;
	logic [13:0] bdata;
	logic burn;
	logic [13:0] q;
	int bad_count;
	int samples_checked;
	wire pin;
	assign pin = oe_n ? sdat : data_o;
	osp_port u_osp_port (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .master_clear_pin_i(master_clear_pin_i),
		.serial_clock_pin_i(sclk), .serial_data_pin_i(pin), .serial_data_pin_o(data_o),
		.serial_data_pin_oe_n_o(oe_n), .prog_mode_o(mode), .hold_reset_o(hold), .mem_addr_o(addr),
		.burn_data_o(bdata), .burn_o(burn), .mem_rdata_i(mem_rdata_i), .wide_variant_i(wide_variant_i));
	osp_prog_model u_osp_prog_model (.clk_sys_i(clk_sys_i), .pin_i(pin), .sclk_o(sclk), .sdat_o(sdat));
	initial begin
		clk_sys_i = 1'b0;
		forever #5 clk_sys_i = ~clk_sys_i;
	end
	// Array contents are a fixed scramble of the address.
	always @(negedge clk_sys_i) mem_rdata_i <= addr ^ 14'h1A5C;
	////////////////////////////////////////////////////////////////
	task automatic chk(input logic [13:0] got, input logic [13:0] exp);
		samples_checked++;
		if (got !== exp) begin
			bad_count++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic results();
		$display("comparisons %0d mismatches %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	// The variant only changes while the mode is off, so no alias sees a moving strap.
	task automatic enter(input logic v);
		master_clear_pin_i = 1'b0;
		repeat (10) @(negedge clk_sys_i);
		wide_variant_i = v;
		master_clear_pin_i = 1'b1;
		repeat (10) @(negedge clk_sys_i);
		chk(14'({mode, hold, oe_n}), 14'h0007);
		chk(addr, 14'h0000);
	endtask
	task automatic t_read();
		for (int i = 0; i < 3; i++) u_osp_prog_model.cmd(CMD_INC_ADDR);
		u_osp_prog_model.cmd(6'h3F);
		chk(addr, 14'h0003);
		u_osp_prog_model.cmd(CMD_READ_DATA);
		u_osp_prog_model.frame(14'h0000, 1'b1, q);
		chk(q, 14'h0003 ^ 14'h1A5C);
		chk(14'(oe_n), 14'h0001);
	endtask
	task automatic t_burn();
		u_osp_prog_model.cmd(CMD_LOAD_DATA);
		u_osp_prog_model.frame(14'h2D69, 1'b0, q);
		u_osp_prog_model.cmd(CMD_BEGIN_PROG);
		chk(bdata, 14'h2D69);
		chk(14'(burn), 14'h0001);
		u_osp_prog_model.cmd(CMD_END_PROG);
		chk(14'(burn), 14'h0000);
		u_osp_prog_model.cmd(CMD_BEGIN_PROG);
		chk(14'(burn), 14'h0000);
	endtask
	task automatic t_cfg(input logic v);
		enter(v);
		u_osp_prog_model.cmd(CMD_LOAD_CFG);
		u_osp_prog_model.frame(14'h000F, 1'b0, q);
		chk(addr, 14'h2000);
		for (int i = 0; i < 128; i++) u_osp_prog_model.cmd(CMD_INC_ADDR);
		chk(addr, v ? 14'h2080 : 14'h2000);
	endtask
	initial begin
		rst_n_i = 1'b0;
		master_clear_pin_i = 1'b0;
		wide_variant_i = 1'b1;
		bad_count = 0;
		samples_checked = 0;
		repeat (8) @(negedge clk_sys_i);
		rst_n_i = 1'b1;
		enter(1'b1);
		t_read();
		t_burn();
		t_cfg(1'b0);
		t_cfg(1'b1);
		results();
	end
	initial begin
		#700us;
		bad_count++;
		results();
	end
endmodule
`default_nettype wire

// file: osp_prog_model.sv
`default_nettype none
module osp_prog_model (
	// System clock and pin level
	input wire logic clk_sys_i,
	input wire logic pin_i,
	// Programmer pins
	output logic sclk_o,
	output logic sdat_o
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		sclk_o = 1'b0;
		sdat_o = 1'b0;
	end
	////////////////////////////////////////////////////////////////
	task automatic half();
		repeat (4) @(negedge clk_sys_i);
	endtask
	// A released line toggles so that a stale value can never pass for a read bit.
	task automatic pulse(input logic b, input logic rel, output logic r);
		sclk_o = 1'b1;
		sdat_o = rel ? ~sdat_o : b;
		half();
		sclk_o = 1'b0;
		half();
		r = pin_i;
	endtask
	task automatic gap();
		repeat (100) @(negedge clk_sys_i);
	endtask
	task automatic cmd(input logic [5:0] c);
		logic r;
		for (int i = 0; i < 6; i++) pulse(c[i], 1'b0, r);
		gap();
	endtask
	task automatic frame(input logic [13:0] w, input logic rd, output logic [13:0] q);
		logic [15:0] d;
		logic [15:0] f;
		d = {1'b0, w, 1'b0};
		for (int i = 0; i < 16; i++) pulse(d[i], rd, f[i]);
		q = f[14:1];
		sdat_o = 1'b0;
		gap();
	endtask
endmodule
`default_nettype wire
